//--- hw/ppc_edge_filt.sv
`timescale 1ns/1ps
module ppc_edge_filt #(
  parameter int N = ppc_pkg::FILT_N
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // sampled level, high when at the active level
  input  wire logic active,
  // one-cycle pulse on a valid edge
  output logic      edge_o
);
  import ppc_pkg::*;

  localparam int CW = $clog2(N + 1);

  logic [CW-1:0] pas_r;
  logic [CW-1:0] pas_nxt;
  logic [CW-1:0] act_r;
  logic [CW-1:0] act_nxt;
  logic          hit;

  // passive run arms, active run fires; any break restarts
  // edge qualification
  always_comb begin
    pas_nxt = pas_r;
    act_nxt = act_r;
    hit     = 1'b0;
    if (!active) begin
      if (act_r != '0) begin
        pas_nxt = CW'(1);
        act_nxt = '0;
      end else if (pas_r != CW'(N)) begin
        pas_nxt = pas_r + CW'(1);
      end
    end else if (pas_r == CW'(N)) begin
      if (act_r == CW'(N - 1)) begin
        hit     = 1'b1;
        pas_nxt = '0;
        act_nxt = '0;
      end else begin
        act_nxt = act_r + CW'(1);
      end
    end else begin
      pas_nxt = '0;
    end
  end

  // counters and pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pas_r  <= '0;
      act_r  <= '0;
      edge_o <= 1'b0;
    end else begin
      pas_r  <= pas_nxt;
      act_r  <= act_nxt;
      edge_o <= hit;
    end
  end

  AST_FILT_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    (!active)[*4] ##1 active[*4] |=> edge_o)
    else $error("qualified edge not reported");

  AST_FILT_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
    edge_o |-> $past(active, 1) && $past(active, 4) && !$past(active, 5)
               && !$past(active, 8))
    else $error("edge reported without full sample runs");

endmodule

//--- hw/ppc_port_ctrl.sv
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Function
// - all configuration registers writable anytime; pin input registers ignore writes
// - configuration acts only where it fits the pin's present use
// - unimplemented register bits read back as zero
// - only the per-port bit ranges exist, reduced drive on bits 7,5,3,1
// - pin input register always returns actual pin level
// - data register read returns pin state where direction bit is 0
// - enabled peripheral may override the general-purpose direction
// - among several enabled peripherals the highest ranked one controls the pin; a lower ranked open-drain one still turns the pulldown off
// - serial peripheral controls direction; pull disabled only while output
// - every interrupt source has local enable except nonmaskable request pin
// - port request raised while a flag bit and its enable are set
// - valid edge needs 4 passive then 4 active samples, else restart
module ppc_port_ctrl #(
  parameter int NSLOT = 2
) (
  // clock and reset
  input  wire logic                                          pclk,
  input  wire logic                                          presetn,
  // apb slave
  input  wire logic                                          psel,
  input  wire logic                                          penable,
  input  wire logic                                          pwrite,
  input  wire logic [11:0]                                   paddr,
  input  wire logic [31:0]                                   pwdata,
  output logic      [31:0]                                   prdata,
  output logic                                               pready,
  output logic                                               pslverr,
  // pins
  input  wire logic [ppc_pkg::NPORT-1:0][7:0]                pad_in,
  output ppc_pkg::ppc_pad_s [ppc_pkg::NPORT-1:0][7:0]        pad_o,
  // peripheral requests, slot 0 ranks highest
  input  ppc_pkg::ppc_per_s [ppc_pkg::NPORT-1:0][7:0][NSLOT-1:0] per_i,
  // interrupt sources
  input  wire logic                                          req_pin_n,
  input  wire logic                                          nmi_pin_n,
  input  wire logic [ppc_pkg::NOC-1:0]                       oc_event,
  // interrupt outputs
  output logic      [ppc_pkg::NPORT-1:0]                     port_irq_o,
  output logic                                               req_irq_o,
  output logic                                               oc_irq_o,
  output logic                                               nmi_req_o,
  output logic                                               irq_o
);
  import ppc_pkg::*;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire        setup    = psel & ~penable;
  wire        acc_done = psel & penable & pready;
  wire        wr       = acc_done & pwrite;
  wire        rd_done  = acc_done & ~pwrite;
  wire [2:0]  a_port   = paddr[8:6];
  wire [3:0]  a_reg    = paddr[5:2];
  wire        port_win = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0)
                         && (a_reg < 4'(NREG));
  wire        hit_stat = (paddr == A_STAT);
  wire        hit_mask = (paddr == A_MASK);
  wire        hit_req  = (paddr == A_REQ);
  wire        hit_ocf  = (paddr == A_OCF);
  wire        hit_oce  = (paddr == A_OCE);
  wire        hit_any  = port_win | hit_stat | hit_mask | hit_req
                         | hit_ocf | hit_oce;
  wire        wr_port  = wr & port_win;
  // implemented-bit map of the addressed register, all ports
  wire [63:0] mask_all = ppc_mask(a_reg);

  logic [NPORT-1:0][7:0] port_rd;
  logic [NPORT-1:0]      port_req;
  logic [NSTAT-1:0]      stat_r;
  logic [NSTAT-1:0]      stat_nxt;
  logic [NSTAT-1:0]      mask_r;
  logic                  req_en_r;
  logic                  req_edge_r;
  logic                  req_pend_r;
  logic                  req_pend_nxt;
  logic                  req_prev_r;
  logic                  req_lvl;
  logic [NOC-1:0]        ocf_r;
  logic [NOC-1:0]        ocf_nxt;
  logic [NOC-1:0]        oce_r;
  logic                  oc_lvl;
  logic [31:0]           rd_val;

  // read mux; unmapped addresses answer zero with an error
  // zero fill
  assign rd_val = port_win ? {24'h0, port_rd[a_port]}
                : hit_stat ? {{(32-NSTAT){1'b0}}, stat_r}
                : hit_mask ? {{(32-NSTAT){1'b0}}, mask_r}
                : hit_req  ? {29'h0, req_pend_r, req_edge_r, req_en_r}
                : hit_ocf  ? {{(32-NOC){1'b0}}, ocf_r}
                : hit_oce  ? {{(32-NOC){1'b0}}, oce_r}
                : 32'h0;

  // answer is prepared in setup so every access ends with no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h0 : rd_val;
        pslverr <= ~hit_any;
      end
    end
  end

  // ************************************************************
  // per-port registers and pins
  // ************************************************************
  genvar p;
  genvar b;
  generate
    for (p = 0; p < NPORT; p++) begin : g_port
      logic [NREG-1:0][7:0] cfg_r;
      logic [7:0]           pif_r;
      logic [7:0]           edge_hit;
      wire  [7:0]           m_pin  = M_IN[p*8 +: 8];
      wire  [7:0]           m_bas  = M_BASIC[p*8 +: 8];
      wire  [7:0]           m_die  = M_DIE[p*8 +: 8];
      wire  [7:0]           m_irq  = M_IRQ[p*8 +: 8];
      wire  [7:0]           pin_m  = pad_in[p] & m_pin;
      wire  [7:0]           dir    = cfg_r[R_DIR];
      wire                  sel    = (a_port == 3'(p));
      wire                  wr_cfg = wr_port & sel & (a_reg != R_PIN)
                                     & (a_reg != R_PIF);
      wire                  wr_pif = wr_port & sel & (a_reg == R_PIF);
      wire  [7:0]           wmask  = mask_all[p*8 +: 8];

      assign port_rd[p] = (a_reg == R_PIN)  ? pin_m
                        : (a_reg == R_DATA) ? (((cfg_r[R_DATA] & dir)
                                              | (pin_m & ~dir)) & m_bas)
                        : (a_reg == R_PIF)  ? pif_r
                        : cfg_r[a_reg];
      assign port_req[p] = |(pif_r & cfg_r[R_PIE]);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_r <= {NREG{CFG_RST}};
        end else if (wr_cfg) begin
          cfg_r[a_reg] <= pwdata[7:0] & wmask;
        end
      end

      // flags clear by writing one; a new edge wins over the clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pif_r <= CFG_RST;
        end else begin
          pif_r <= ((pif_r & ~(wr_pif ? pwdata[7:0] : 8'h00)) | edge_hit)
                   & m_irq;
        end
      end

      for (b = 0; b < 8; b++) begin : g_bit
        logic     oe;
        logic     out;
        logic     od;
        logic     pd_off;
        logic     drv;
        ppc_pad_s pad_nxt;

        // active level follows the polarity select
        ppc_edge_filt #(
          .N       (FILT_N)
        ) u_filt (
          .pclk    (pclk),
          .presetn (presetn),
          .active  (pad_in[p][b] ~^ cfg_r[R_POL][b]),
          .edge_o  (edge_hit[b])
        );

        // lowest slot number is applied last and therefore wins
        // peripheral override
        always_comb begin
          oe     = dir[b];
          out    = cfg_r[R_DATA][b];
          od     = cfg_r[R_WOM][b];
          pd_off = 1'b0;
          for (int s = NSLOT - 1; s >= 0; s--) begin
            if (per_i[p][b][s].en) begin
              case (per_i[p][b][s].kind)
                K_DRIVE: begin
                  oe  = 1'b1;
                  out = per_i[p][b][s].out;
                  od  = 1'b0;
                end
                K_RECV: begin
                  oe = 1'b0;
                end
                K_BIDIR: begin
                  oe  = per_i[p][b][s].oe;
                  out = per_i[p][b][s].out;
                  od  = 1'b0;
                end
                K_ODRAIN: begin
                  oe     = 1'b1;
                  out    = per_i[p][b][s].out;
                  od     = 1'b1;
                  pd_off = 1'b1;
                end
                default: begin
                  oe = dir[b];
                end
              endcase
            end
          end
          // an open-drain pin drives only its low level
          drv = oe & ~(od & out);
        end

        // pulls act only while the pin is not driven
        // pull only when released
        assign pad_nxt.out     = out & ~od;
        assign pad_nxt.oe      = drv & m_bas[b];
        assign pad_nxt.pull_up = cfg_r[R_PULL][b] & ~cfg_r[R_POL][b] & ~drv;
        assign pad_nxt.pull_dn = cfg_r[R_PULL][b] & cfg_r[R_POL][b] & ~drv
                                 & ~pd_off;
        assign pad_nxt.in_en   = m_pin[b] & (m_die[b] ? cfg_r[R_DIE][b] : 1'b1);
        assign pad_nxt.low_drv = cfg_r[R_RDR][b];

        // pad controls leave through a flop
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            pad_o[p][b] <= '0;
          end else begin
            pad_o[p][b] <= pad_nxt;
          end
        end

        AST_PULL_OFF_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
          pad_o[p][b].oe |-> !pad_o[p][b].pull_up && !pad_o[p][b].pull_dn)
          else $error("pull active on a driven pin");

        AST_FORCE_OUT: assert property (@(posedge pclk) disable iff (!presetn)
          (m_bas[b] && per_i[p][b][0].en && per_i[p][b][0].kind == K_DRIVE)
          |=> pad_o[p][b].oe && pad_o[p][b].out == $past(per_i[p][b][0].out))
          else $error("driving peripheral did not take the pin");

        AST_RANK: assert property (@(posedge pclk) disable iff (!presetn)
          (per_i[p][b][0].en && per_i[p][b][0].kind == K_RECV)
          |=> !pad_o[p][b].oe)
          else $error("lower ranked peripheral drove the pin");

        AST_ODRAIN: assert property (@(posedge pclk) disable iff (!presetn)
          (per_i[p][b][0].en && per_i[p][b][0].kind == K_ODRAIN)
          |=> !pad_o[p][b].pull_dn && !pad_o[p][b].out)
          else $error("open-drain pin drove high or kept pulldown");
      end

      AST_PORT_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        port_req[p] |=> port_irq_o[p])
        else $error("port request not raised");
    end
  endgenerate

  // ************************************************************
  // request pin, nonmaskable pin, over-current
  // ************************************************************
  wire wr_req  = wr & hit_req;
  wire fall    = req_prev_r & ~req_pin_n;
  wire req_clr = wr_req & pwdata[REQ_PEND_BIT];
  wire [NOC-1:0] oc_clr = (wr & hit_ocf) ? pwdata[NOC-1:0] : '0;

  // disabling drops a pending request; a new edge beats the clear
  // local enables
  assign req_pend_nxt = req_en_r & ((req_pend_r & ~req_clr)
                        | (req_edge_r & fall));
  assign req_lvl      = req_en_r & (req_edge_r ? req_pend_nxt : ~req_pin_n);
  assign ocf_nxt      = (ocf_r & ~oc_clr) | oc_event;
  assign oc_lvl       = |(ocf_nxt & oce_r);

  // request pin control and state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_en_r   <= 1'b0;
      req_edge_r <= 1'b0;
      req_pend_r <= 1'b0;
      req_prev_r <= PIN_IDLE;
    end else begin
      if (wr_req) begin
        req_en_r   <= pwdata[REQ_EN_BIT];
        req_edge_r <= pwdata[REQ_EDGE_BIT];
      end
      req_pend_r <= req_pend_nxt;
      req_prev_r <= req_pin_n;
    end
  end

  // over-current flags and enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ocf_r <= '0;
      oce_r <= '0;
    end else begin
      ocf_r <= ocf_nxt;
      if (wr & hit_oce) begin
        oce_r <= pwdata[NOC-1:0];
      end
    end
  end

  // ************************************************************
  // interrupt status, mask, outputs
  // ************************************************************
  wire [NSTAT-1:0] lvl_now = {oc_lvl, req_lvl, port_req};
  wire [NSTAT-1:0] lvl_old = {oc_irq_o, req_irq_o, port_irq_o};
  // only bits the reader actually saw are cleared, so a late set survives
  wire [NSTAT-1:0] rd_clr  = (rd_done & hit_stat) ? prdata[NSTAT-1:0] : '0;

  assign stat_nxt = (stat_r & ~rd_clr) | (lvl_now & ~lvl_old);

  // source levels and summary line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r     <= STAT_RST;
      mask_r     <= STAT_RST;
      port_irq_o <= '0;
      req_irq_o  <= 1'b0;
      oc_irq_o   <= 1'b0;
      nmi_req_o  <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      stat_r     <= stat_nxt;
      if (wr & hit_mask) begin
        mask_r <= pwdata[NSTAT-1:0];
      end
      port_irq_o <= port_req;
      req_irq_o  <= req_lvl;
      oc_irq_o   <= oc_lvl;
      nmi_req_o  <= ~nmi_pin_n; // no local enable on purpose
      irq_o      <= |(stat_nxt & mask_r);
    end
  end

  AST_PIN_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && port_win && a_reg == R_PIN)
    |=> prdata[7:0] == ($past(pad_in[a_port]) & $past(M_IN[a_port*8 +: 8])))
    else $error("pin register did not return pin level");

  AST_UNIMPL_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && port_win)
    |=> prdata[31:8] == 24'h0
        && (prdata[7:0] & ~$past(mask_all[a_port*8 +: 8])) == 8'h00)
    else $error("unimplemented bit read nonzero");

  AST_REQ_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (!req_en_r && !$past(req_en_r)) |-> !req_irq_o)
    else $error("request pin fired while disabled");

  AST_NMI: assert property (@(posedge pclk) disable iff (!presetn)
    !nmi_pin_n |=> nmi_req_o)
    else $error("nonmaskable request lost");

endmodule

//--- shared/ppc_pkg.sv
package ppc_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int NPORT = 8;
  localparam int NREG  = 10;
  localparam int NSTAT = 10;
  localparam int NOC   = 4;
  localparam int FILT_N = 4;

  // ************************************************************
  // port window: port p at p*0x40, register r at r*4
  // ************************************************************
  localparam logic [3:0] R_DATA = 4'h0;
  localparam logic [3:0] R_PIN  = 4'h1;
  localparam logic [3:0] R_DIR  = 4'h2;
  localparam logic [3:0] R_PULL = 4'h3;
  localparam logic [3:0] R_POL  = 4'h4;
  localparam logic [3:0] R_PIE  = 4'h5;
  localparam logic [3:0] R_PIF  = 4'h6;
  localparam logic [3:0] R_DIE  = 4'h7;
  localparam logic [3:0] R_RDR  = 4'h8;
  localparam logic [3:0] R_WOM  = 4'h9;

  // global registers
  localparam logic [11:0] A_STAT = 12'h200;
  localparam logic [11:0] A_MASK = 12'h204;
  localparam logic [11:0] A_REQ  = 12'h208;
  localparam logic [11:0] A_OCF  = 12'h20c;
  localparam logic [11:0] A_OCE  = 12'h210;

  // field positions
  localparam int REQ_EN_BIT   = 0;
  localparam int REQ_EDGE_BIT = 1;
  localparam int REQ_PEND_BIT = 2;
  localparam int STAT_REQ_BIT = 8;
  localparam int STAT_OC_BIT  = 9;

  // reset values
  localparam logic [7:0]       CFG_RST  = 8'h00;
  localparam logic [NSTAT-1:0] STAT_RST = 10'h000;
  localparam logic             PIN_IDLE = 1'b1;

  // ************************************************************
  // implemented bits, byte p = port p (E,ADH,ADL,T,S,P,J,L)
  // ************************************************************
  localparam logic [63:0] M_BASIC = 64'h00_03_ff_0f_ff_ff_03_03;
  localparam logic [63:0] M_IN    = 64'h01_03_ff_0f_ff_ff_03_03;
  localparam logic [63:0] M_IRQ   = 64'h01_00_ff_0f_00_ff_03_00;
  localparam logic [63:0] M_DIE   = 64'h01_00_00_00_00_ff_03_00;
  localparam logic [63:0] M_RDR   = 64'h00_00_aa_00_00_00_00_00;
  localparam logic [63:0] M_WOM   = 64'h00_03_00_0f_00_00_00_00;
  // port that owns the over-current bits 7,5,3,1
  localparam int OC_PORT = 5;

  typedef enum logic [1:0] {
    K_DRIVE  = 2'b00,
    K_RECV   = 2'b01,
    K_ODRAIN = 2'b11,
    K_BIDIR  = 2'b10
  } ppc_kind_e;

  // one peripheral request on a pin
  typedef struct packed {
    logic      en;
    ppc_kind_e kind;
    logic      oe;
    logic      out;
  } ppc_per_s;

  // pad control for one pin
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_dn;
    logic in_en;
    logic low_drv;
  } ppc_pad_s;

  function automatic logic [63:0] ppc_mask(input logic [3:0] r);
    case (r)
      R_DATA, R_DIR, R_PULL: ppc_mask = M_BASIC;
      R_PIN, R_POL:          ppc_mask = M_IN;
      R_PIE, R_PIF:          ppc_mask = M_IRQ;
      R_DIE:                 ppc_mask = M_DIE;
      R_RDR:                 ppc_mask = M_RDR;
      R_WOM:                 ppc_mask = M_WOM;
      default:               ppc_mask = '0;
    endcase
  endfunction

endpackage

//--- tb/port_pin_control_block_tb_top.sv
`timescale 1ns/1ps
module port_pin_control_block_tb_top;
  import ppc_pkg::*;
  // ************************************************************
  // stimulus and observation
  // ************************************************************
  logic                               pclk = 0, presetn = 0;
  logic                               psel = 0, penable = 0, pwrite = 0;
  logic [11:0]                        paddr = '0;
  logic [31:0]                        pwdata = '0, prdata, q;
  logic                               pready, pslverr, lerr;
  logic [NPORT-1:0][7:0]              pad_in = '1;
  ppc_pad_s [NPORT-1:0][7:0]          pad_o;
  ppc_per_s [NPORT-1:0][7:0][1:0]     per_i = '0;
  logic                               req_pin_n = 1, nmi_pin_n = 1;
  logic [NOC-1:0]                     oc_event = '0;
  logic [NPORT-1:0]                   port_irq_o;
  logic                               req_irq_o, oc_irq_o, nmi_req_o, irq_o;
  logic [31:0]                        seed = 32'd54;
  logic [7:0]                         dv, vv, pv;
  int                                 errors = 0, tests_run = 0, n;

  ppc_port_ctrl #(.NSLOT(2)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_o(pad_o), .per_i(per_i),
    .req_pin_n(req_pin_n), .nmi_pin_n(nmi_pin_n), .oc_event(oc_event),
    .port_irq_o(port_irq_o), .req_irq_o(req_irq_o), .oc_irq_o(oc_irq_o),
    .nmi_req_o(nmi_req_o), .irq_o(irq_o));

  initial begin
    forever #25 pclk = ~pclk;
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // implemented bits of one port, from the table constants
  function logic [7:0] mb(input logic [63:0] m, input int p);
    return m[p*8 +: 8];
  endfunction
  function logic [11:0] ra(input int p, input logic [3:0] r);
    return 12'(p * 64 + int'(r) * 4);
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      give_verdict();
    end
    q = prdata;
    lerr = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // k 0 waits for the port P request, k 1 for the request pin
  task automatic waitfor(input int k);
    n = 0;
    while ((k == 0 ? port_irq_o[5] : req_irq_o) !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) begin
      errors++;
      give_verdict();
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    wt(2);
    presetn <= 1;
    @(posedge pclk);
    apb(0, ra(2, R_DIR), 0); chk(q, 0);
    apb(0, 12'h3fc, 0); chk({lerr, q}, 33'h1_0000_0000);
    // random register contents and pin levels, every port
    for (int p = 0; p < NPORT; p++) begin
      pad_in <= {xs(), xs()};
      dv = xs(); vv = xs(); pv = xs();
      apb(1, ra(p, R_DIE), 32'hff);
      apb(1, ra(p, R_DIR), {24'h0, dv});
      apb(1, ra(p, R_DATA), {24'h0, vv});
      apb(1, ra(p, R_PIN), {24'h0, pv});
      wt(4);
      apb(0, ra(p, R_PIN), 0); chk(q, mb(M_IN, p) & pad_in[p]);
      apb(0, ra(p, R_DATA), 0);
      chk(q, mb(M_BASIC, p) & ((dv & vv) | (~dv & pad_in[p])));
      apb(0, ra(p, R_DIR), 0); chk(q, mb(M_BASIC, p) & dv);
      vv = xs(); apb(1, ra(p, R_RDR), {24'h0, vv}); apb(0, ra(p, R_RDR), 0);
      pv = mb(M_RDR, p) & vv;
      chk(q, pv);
      chk(pad_o[p][1].low_drv, pv[1]);
      vv = xs(); apb(1, ra(p, R_WOM), {24'h0, vv}); apb(0, ra(p, R_WOM), 0);
      chk(q, mb(M_WOM, p) & vv);
      vv = xs(); apb(1, ra(p, R_PIE), 0);
      apb(1, ra(p, R_POL), {24'h0, vv}); apb(0, ra(p, R_POL), 0);
      chk(q, mb(M_IN, p) & vv);
    end
    // peripheral override on port T pin 0, pullup selected
    pad_in <= '1;
    apb(1, ra(3, R_DIR), 0); apb(1, ra(3, R_PULL), 1); apb(1, ra(3, R_POL), 0);
    // routing set up before the peripheral acts on the pin
    per_i[3][0][1] <= '{en: 1, kind: K_RECV, oe: 0, out: 0};
    wt(3); chk({pad_o[3][0].oe, pad_o[3][0].pull_up}, 2'b01);
    per_i[3][0][0] <= '{en: 1, kind: K_DRIVE, oe: 1, out: 1};
    wt(3); chk({pad_o[3][0].oe, pad_o[3][0].out, pad_o[3][0].pull_up}, 3'b110);
    apb(1, ra(3, R_POL), 1);
    per_i[3][0][0] <= '{en: 1, kind: K_ODRAIN, oe: 0, out: 0};
    wt(3); chk(pad_o[3][0].pull_dn, 0);
    per_i[3][0] <= '0;
    wt(3); chk({pad_o[3][0].oe, pad_o[3][0].pull_dn}, 2'b01);
    apb(1, ra(3, R_DIR), 1);
    wt(3); chk({pad_o[3][0].oe, pad_o[3][0].pull_dn}, 2'b10);
    // pin interrupt on port P pin 0, falling active
    apb(1, ra(5, R_POL), 0); apb(1, ra(5, R_PIE), 1); wt(10);
    apb(1, ra(5, R_PIF), 32'hff); apb(0, A_STAT, 0); apb(1, A_MASK, 32'h20);
    pad_in[5][0] <= 0; wt(3); pad_in[5][0] <= 1; wt(10);
    apb(0, ra(5, R_PIF), 0); chk(q, 0);
    pad_in[5][0] <= 0;
    waitfor(0); chk(port_irq_o[5], 1);
    wt(2); chk(irq_o, 1);
    apb(0, A_STAT, 0); chk(q[5], 1);
    apb(0, A_STAT, 0); chk(q[5], 0);
    wt(2); chk(irq_o, 0);
    apb(1, ra(5, R_PIE), 0); wt(2); chk(port_irq_o[5], 0);
    apb(0, ra(5, R_PIF), 0); chk(q[0], 1);
    // request, nonmaskable and over-current sources
    req_pin_n <= 0; nmi_pin_n <= 0; oc_event <= 4'h1; wt(5);
    chk({req_irq_o, nmi_req_o, oc_irq_o}, 3'b010);
    apb(0, A_OCF, 0); chk(q[0], 1);
    apb(1, A_OCE, 1); apb(1, A_REQ, 1);
    waitfor(1); chk({req_irq_o, oc_irq_o}, 2'b11);
    give_verdict();
  end
endmodule
